// file: core/cnt_pkg.sv
// Shared types and constants for the position and edge-separation counter
// What this block does
// - Nothing counts until software arms; readout style chosen beforehand.
// - X1 counts up on A rising when A leads, down on A falling otherwise.
// - X2 steps on both edges of A, two steps per cycle.
// - X4 steps on every edge of A and B, four steps per cycle.
// - Index high loads the reload value in the chosen A/B phase, except in two-pulse mode.
// - Reload phase may be any of the four A/B level pairs.
// - Reload only while chosen phase and index high coincide.
// - A step due with a reload is applied first, reload after.
// - Reload lands one clock after the phase becomes true, or two when a step enters the phase.
// - After reload, decoding carries on from the loaded value unchanged.
// - Two-pulse mode adds on A rising, subtracts on B rising.
// - Buffered position captures count on each sample edge, never clearing.
// - Sample edge polarity selectable; sample clock is the gate input.
// - Each captured position goes out on the transfer stream unless the buffer is full.
// - Armed edge separation starts counting source edges on aux edge.
// - Further aux edges are ignored while counting.
// - Gate edge copies count to the save register; in single separation it also stops counting.
// - Aux and gate active polarities are set independently.
// - Single separation ignores all inputs but disarm after saving.
// - Buffered separation restarts on the gate edge; saves go out streamed.
// - Count is 32 bits wide.
package cnt_pkg;

	// Count width and reset values
	localparam int CNT_W = 32;
	localparam logic [CNT_W-1:0] COUNT_RST = 32'h0000_0000;
	localparam logic [CNT_W-1:0] COUNT_ONE = 32'h0000_0001;
	localparam logic [1:0] PHASE_RST = 2'h0;

	// Measurement modes
	typedef enum logic [2:0] {
		MODE_X1 = 3'h0,
		MODE_X2 = 3'h1,
		MODE_X4 = 3'h2,
		MODE_TWO_PULSE = 3'h3,
		MODE_SEP_SINGLE = 3'h4,
		MODE_SEP_BUF = 3'h5
	} mode_e;

	// Run states, Gray coded along idle, wait, count, done
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_WAIT = 2'h1,
		ST_COUNT = 2'h3,
		ST_DONE = 2'h2
	} state_e;

	// Input pins travelling together through the synchroniser
	typedef struct packed {
		logic enc_a;
		logic enc_b;
		logic index_input;
		logic gate;
		logic aux;
		logic src;
	} pins_s;

	// Configuration captured at arm time
	typedef struct packed {
		mode_e mode;
		logic buffered;
		logic samp_rise;
		logic aux_rise;
		logic gate_rise;
		logic src_rise;
		logic reload_en;
		logic [1:0] reload_phase;
	} cfg_s;

endpackage

// file: core/pair_buffer.sv
// Two-entry valid/ready buffer with the head always in one register
`timescale 1ns/1ns
`default_nettype none
module pair_buffer #(
	parameter int W = 32
) (
	input wire logic mclk_i, // Clock
	input wire logic rst_b_i, // Async reset, active low
	input wire logic in_valid_i, // Word offered
	input wire logic [W-1:0] in_data_i, // Offered word
	output logic in_ready_o, // Room for a word
	output logic out_valid_o, // Head word valid
	output logic [W-1:0] out_data_o, // Head word
	input wire logic out_ready_i // Drain accepts head
);

	logic [W-1:0] tail_ff;
	logic tail_vld_ff;
	logic push;
	logic pop;

	// Handshakes on both sides
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	// Head register feeds the drain side directly
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			out_data_o <= '0;
			out_valid_o <= 1'b0;
		end else if (pop) begin
			out_data_o <= tail_vld_ff ? tail_ff : in_data_i;
			out_valid_o <= tail_vld_ff | push;
		end else if (!out_valid_o && push) begin
			out_data_o <= in_data_i;
			out_valid_o <= 1'b1;
		end
	end

	// Second slot holds a word while the drain stalls
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tail_ff <= '0;
			tail_vld_ff <= 1'b0;
			in_ready_o <= 1'b1;
		end else begin
			if (push && ((pop && tail_vld_ff) || (!pop && out_valid_o)))
				tail_ff <= in_data_i;
			if (pop && !push) begin
				tail_vld_ff <= 1'b0;
				in_ready_o <= 1'b1;
			end else if (!pop && push && out_valid_o) begin
				tail_vld_ff <= 1'b1;
				in_ready_o <= 1'b0;
			end
		end
	end

endmodule // pair_buffer
`default_nettype wire

// file: core/counter_position_edge_separation.sv
// Position decoder and two-signal edge-separation counter
`timescale 1ns/1ns
`default_nettype none
module counter_position_edge_separation #(
	parameter int CW = cnt_pkg::CNT_W
) (
	input wire logic mclk_i, // Fastest timebase
	input wire logic rst_b_i, // Async reset, active low
	input wire logic arm_i, // Arm pulse
	input wire logic disarm_i, // Disarm pulse, back to idle
	input wire cnt_pkg::mode_e mode_i, // Measurement mode
	input wire logic buffered_i, // Position: sample-clocked capture
	input wire logic samp_rise_i, // Sample on gate rising, else falling
	input wire logic aux_rise_i, // Aux active edge rising, else falling
	input wire logic gate_rise_i, // Gate active edge rising, else falling
	input wire logic src_rise_i, // Count source rising, else falling
	input wire logic reload_en_i, // Index reload enabled
	input wire logic [1:0] reload_phase_i, // Reload phase {A,B}
	input wire logic [CW-1:0] reload_val_i, // Value loaded on index
	input wire logic enc_a_i, // Encoder channel A
	input wire logic enc_b_i, // Encoder channel B
	input wire logic index_input_i, // Encoder index channel
	input wire logic gate_i, // Gate / sample clock
	input wire logic aux_i, // Aux start input
	input wire logic src_i, // Count source
	input wire logic dma_ready_i, // Transfer engine takes word
	output logic dma_valid_o, // Word for host memory valid
	output logic [CW-1:0] dma_data_o, // Word for host memory
	output logic capture_ready_o, // Buffer has room
	output logic overrun_o, // Sticky: capture lost on full
	output logic [CW-1:0] count_o, // Live count, on-demand readout
	output logic [CW-1:0] save_o, // Hardware save register
	output logic save_done_o, // Single separation result ready
	output logic armed_o, // Counter armed
	output logic counting_o // Counting in progress
);

	// Step decode shared by every quadrature and two-pulse mode
	function automatic logic [1:0] step_of(
		input cnt_pkg::mode_e mode,
		input logic pa,
		input logic pb,
		input logic a,
		input logic b
	);
		logic a_r;
		logic a_f;
		logic b_r;
		logic b_f;
		logic up;
		logic dn;
		a_r = a & ~pa;
		a_f = ~a & pa;
		b_r = b & ~pb;
		b_f = ~b & pb;
		up = 1'b0;
		dn = 1'b0;
		unique case (mode)
			cnt_pkg::MODE_X1: begin
				up = a_r & ~b;
				dn = a_f & ~b;
			end
			cnt_pkg::MODE_X2: begin
				up = (a_r & ~b) | (a_f & b);
				dn = (a_r & b) | (a_f & ~b);
			end
			cnt_pkg::MODE_X4: begin
				up = (a_r & ~b) | (a_f & b) | (b_r & a) | (b_f & ~a);
				dn = (a_r & b) | (a_f & ~b) | (b_r & ~a) | (b_f & a);
			end
			cnt_pkg::MODE_TWO_PULSE: begin
				up = a_r;
				dn = b_r;
			end
			default: begin
				up = 1'b0;
				dn = 1'b0;
			end
		endcase
		// Both channels moving at once carries no direction
		if (up && dn) begin
			up = 1'b0;
			dn = 1'b0;
		end
		return {up, dn};
	endfunction

	// Chosen edge of a synchronised level
	function automatic logic edge_of(
		input logic prev,
		input logic cur,
		input logic rise
	);
		return rise ? (cur & ~prev) : (~cur & prev);
	endfunction

	cnt_pkg::pins_s pins;
	cnt_pkg::pins_s sync1_ff;
	cnt_pkg::pins_s sync2_ff;
	cnt_pkg::pins_s prev_ff;
	cnt_pkg::cfg_s cfg_in;
	cnt_pkg::cfg_s cfg_ff;
	cnt_pkg::state_e state_ff;
	cnt_pkg::state_e nxt_state;
	logic [CW-1:0] count_ff;
	logic [CW-1:0] nxt_count;
	logic [1:0] step;
	logic is_pos;
	logic pos_run;
	logic sep_run;
	logic phase_hit;
	logic reload_due;
	logic samp_edge;
	logic aux_edge;
	logic gate_edge;
	logic src_edge;
	logic push_valid;
	logic [CW-1:0] push_data;
	logic buf_ready;

	// Gather pins and settings into their carriers
	assign pins = '{enc_a: enc_a_i, enc_b: enc_b_i, index_input: index_input_i,
		gate: gate_i, aux: aux_i, src: src_i};
	assign cfg_in = '{mode: mode_i, buffered: buffered_i, samp_rise: samp_rise_i,
		aux_rise: aux_rise_i, gate_rise: gate_rise_i, src_rise: src_rise_i,
		reload_en: reload_en_i, reload_phase: reload_phase_i};

	// Two-flop synchroniser; only the second stage is looked at
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= pins;
			sync2_ff <= sync1_ff;
		end
	end

	// Previous synchronised levels for edge detection
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prev_ff <= '0;
		end else begin
			prev_ff <= sync2_ff;
		end
	end

	// Configuration is frozen at arm so a running measurement stays stable
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cfg_ff <= '{mode: cnt_pkg::MODE_X1, buffered: 1'b0, samp_rise: 1'b1,
				aux_rise: 1'b1, gate_rise: 1'b1, src_rise: 1'b1,
				reload_en: 1'b0, reload_phase: cnt_pkg::PHASE_RST};
		end else if (arm_i && state_ff == cnt_pkg::ST_IDLE) begin
			cfg_ff <= cfg_in;
		end
	end

	// Mode classes
	assign is_pos = cfg_ff.mode inside {cnt_pkg::MODE_X1, cnt_pkg::MODE_X2,
		cnt_pkg::MODE_X4, cnt_pkg::MODE_TWO_PULSE};
	assign pos_run = is_pos && state_ff == cnt_pkg::ST_COUNT;
	assign sep_run = !is_pos && state_ff == cnt_pkg::ST_COUNT;

	// Edge events on the synchronised inputs
	assign step = pos_run ? step_of(cfg_ff.mode, prev_ff.enc_a, prev_ff.enc_b,
		sync2_ff.enc_a, sync2_ff.enc_b) : 2'b00;
	assign samp_edge = edge_of(prev_ff.gate, sync2_ff.gate, cfg_ff.samp_rise);
	assign aux_edge = edge_of(prev_ff.aux, sync2_ff.aux, cfg_ff.aux_rise);
	assign gate_edge = edge_of(prev_ff.gate, sync2_ff.gate, cfg_ff.gate_rise);
	assign src_edge = edge_of(prev_ff.src, sync2_ff.src, cfg_ff.src_rise);

	// Index reload: chosen phase present together with index high
	assign phase_hit = {sync2_ff.enc_a, sync2_ff.enc_b} == cfg_ff.reload_phase;
	assign reload_due = pos_run && cfg_ff.reload_en && cfg_ff.mode != cnt_pkg::MODE_TWO_PULSE
		&& phase_hit && sync2_ff.index_input;

	// Run state: idle until armed, then wait for aux or count
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			cnt_pkg::ST_IDLE: begin
				if (arm_i) begin
					nxt_state = (cfg_in.mode inside {cnt_pkg::MODE_SEP_SINGLE,
						cnt_pkg::MODE_SEP_BUF}) ? cnt_pkg::ST_WAIT
						: cnt_pkg::ST_COUNT;
				end
			end
			cnt_pkg::ST_WAIT: begin
				if (aux_edge)
					nxt_state = cnt_pkg::ST_COUNT;
			end
			cnt_pkg::ST_COUNT: begin
				if (sep_run && gate_edge && cfg_ff.mode == cnt_pkg::MODE_SEP_SINGLE)
					nxt_state = cnt_pkg::ST_DONE;
			end
			cnt_pkg::ST_DONE: begin
				nxt_state = cnt_pkg::ST_DONE;
			end
		endcase
		if (disarm_i)
			nxt_state = cnt_pkg::ST_IDLE;
	end

	// State register
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_ff <= cnt_pkg::ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Next count for every mode
	always_comb begin
		nxt_count = count_ff;
		if (state_ff == cnt_pkg::ST_IDLE && arm_i) begin
			nxt_count = cnt_pkg::COUNT_RST;
		end else if (pos_run) begin
			if (step[1])
				nxt_count = count_ff + cnt_pkg::COUNT_ONE;
			else if (step[0])
				nxt_count = count_ff - cnt_pkg::COUNT_ONE;
			else if (reload_due)
				nxt_count = reload_val_i;
		end else if (sep_run) begin
			if (gate_edge && cfg_ff.mode == cnt_pkg::MODE_SEP_BUF)
				nxt_count = src_edge ? cnt_pkg::COUNT_ONE : cnt_pkg::COUNT_RST;
			else if (gate_edge)
				nxt_count = count_ff;
			else if (src_edge)
				nxt_count = count_ff + cnt_pkg::COUNT_ONE;
		end
	end

	// Count register, also the on-demand readout
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			count_ff <= cnt_pkg::COUNT_RST;
		end else begin
			count_ff <= nxt_count;
		end
	end

	// Hardware save register and single-result flag
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			save_o <= cnt_pkg::COUNT_RST;
			save_done_o <= 1'b0;
		end else if (state_ff == cnt_pkg::ST_IDLE && arm_i) begin
			save_done_o <= 1'b0;
		end else if (sep_run && gate_edge) begin
			save_o <= src_edge ? count_ff + cnt_pkg::COUNT_ONE : count_ff;
			save_done_o <= cfg_ff.mode == cnt_pkg::MODE_SEP_SINGLE;
		end
	end

	// Words bound for host memory
	always_comb begin
		push_valid = 1'b0;
		push_data = count_ff;
		if (pos_run && cfg_ff.buffered && samp_edge) begin
			push_valid = 1'b1;
			push_data = count_ff;
		end else if (sep_run && gate_edge && cfg_ff.mode == cnt_pkg::MODE_SEP_BUF) begin
			push_valid = 1'b1;
			push_data = src_edge ? count_ff + cnt_pkg::COUNT_ONE : count_ff;
		end
	end

	// Two-entry buffer toward the transfer engine
	pair_buffer #(
		.W(CW)
	) u_buf (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(push_valid),
		.in_data_i(push_data),
		.in_ready_o(buf_ready),
		.out_valid_o(dma_valid_o),
		.out_data_o(dma_data_o),
		.out_ready_i(dma_ready_i)
	);

	// Sticky loss flag, cleared by a new arm; a loss in that cycle wins
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			overrun_o <= 1'b0;
		end else if (push_valid && !buf_ready) begin
			overrun_o <= 1'b1;
		end else if (state_ff == cnt_pkg::ST_IDLE && arm_i) begin
			overrun_o <= 1'b0;
		end
	end

	// Registered status outputs
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			armed_o <= 1'b0;
			counting_o <= 1'b0;
		end else begin
			armed_o <= nxt_state != cnt_pkg::ST_IDLE;
			counting_o <= nxt_state == cnt_pkg::ST_COUNT;
		end
	end

	// Mirrors of internal registers
	assign count_o = count_ff;
	assign capture_ready_o = buf_ready;

endmodule // counter_position_edge_separation
`default_nettype wire

// file: dv/cnt_monitor.sv
// Checker for the position and edge-separation counter ports
`timescale 1ns/1ns
`default_nettype none
module cnt_monitor #(
	parameter int CW = 32
) (
	input wire logic mclk_i, // Clock
	input wire logic rst_b_i, // Reset, active low
	input wire logic arm_i, // Arm pulse
	input wire logic disarm_i, // Disarm pulse
	input wire cnt_pkg::mode_e mode_i, // Mode
	input wire logic reload_en_i, // Reload enable
	input wire logic gate_rise_i, // Gate polarity
	input wire logic enc_a_i, // Channel A
	input wire logic enc_b_i, // Channel B
	input wire logic gate_i, // Gate
	input wire logic dma_ready_i, // Drain ready
	input wire logic dma_valid_o, // Word valid
	input wire logic [CW-1:0] dma_data_o, // Word
	input wire logic capture_ready_o, // Room
	input wire logic overrun_o, // Lost capture
	input wire logic [CW-1:0] count_o, // Live count
	input wire logic [CW-1:0] save_o, // Save register
	input wire logic save_done_o, // Result ready
	input wire logic armed_o, // Armed
	input wire logic counting_o // Counting
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	// Arm starts from a cleared count and result
	chk_arm_clears: assert property (arm_i && !armed_o |=> armed_o && count_o == '0 && !save_done_o)
		else $error("arm did not clear");
	// Nothing counts while idle
	chk_idle_holds: assert property (!armed_o && !arm_i |=> $stable(count_o))
		else $error("count moved while idle");
	chk_count_armed: assert property (counting_o |-> armed_o)
		else $error("counting while not armed");
	// Forward A edge in single-edge mode adds one three edges later
	chk_x1_up: assert property (mode_i == cnt_pkg::MODE_X1 && counting_o
		&& !reload_en_i && !disarm_i && $rose(enc_a_i) && !enc_b_i && $stable(enc_b_i)
		|-> ##3 count_o == $past(count_o) + cnt_pkg::COUNT_ONE)
		else $error("X1 step wrong");
	chk_gate_saves: assert property (mode_i == cnt_pkg::MODE_SEP_SINGLE && counting_o
		&& gate_rise_i && $rose(gate_i) && !disarm_i |-> ##3 save_done_o)
		else $error("gate did not save");
	chk_save_stops: assert property ($rose(save_done_o) |-> !counting_o)
		else $error("still counting after save");
	chk_done_holds: assert property (save_done_o && !arm_i && !disarm_i |=> save_done_o && $stable(save_o))
		else $error("saved result disturbed");
	chk_word_holds: assert property (dma_valid_o && !dma_ready_i |=> dma_valid_o && $stable(dma_data_o))
		else $error("stream word lost");
	chk_full_valid: assert property (!capture_ready_o |-> dma_valid_o)
		else $error("full but nothing offered");
	chk_overrun_sticky: assert property (overrun_o && !arm_i |=> overrun_o)
		else $error("overrun flag dropped");
	cov_pop: cover property (dma_valid_o && dma_ready_i);
	cov_save: cover property ($rose(save_done_o));
	cov_overrun: cover property ($rose(overrun_o));
endmodule // cnt_monitor
bind counter_position_edge_separation cnt_monitor #(.CW(CW)) mon (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
	.arm_i(arm_i), .disarm_i(disarm_i), .mode_i(mode_i), .reload_en_i(reload_en_i),
	.gate_rise_i(gate_rise_i), .enc_a_i(enc_a_i), .enc_b_i(enc_b_i), .gate_i(gate_i),
	.dma_ready_i(dma_ready_i), .dma_valid_o(dma_valid_o), .dma_data_o(dma_data_o),
	.capture_ready_o(capture_ready_o), .overrun_o(overrun_o), .count_o(count_o), .save_o(save_o),
	.save_done_o(save_done_o), .armed_o(armed_o), .counting_o(counting_o));
`default_nettype wire

// file: dv/enc_model.sv
// Encoder and edge-signal source model
`timescale 1ns/1ns
`default_nettype none
module enc_model (
	input wire logic mclk_i, // Clock
	output var cnt_pkg::pins_s pins_o // Encoder and edge lines
);
	int hold = 4; // Cycles each level stands; raise to act slowly
	int ph = 0; // Quadrature phase 0..3
	logic idx_en = 1'h0; // Index pulses enabled
	int idx_ph = 0; // Quadrature phase in which index is high
	initial pins_o = '0;
	// n quadrature steps in direction dir; A and B never change together
	// Both tasks return on a falling edge, so callers read settled outputs
	task quad(input int dir, input int n);
		for (int i = 0; i < n; i++) begin
			ph = (ph + dir + 4) % 4;
			@(posedge mclk_i);
			pins_o.enc_a <= (ph == 1 || ph == 2);
			pins_o.enc_b <= (ph == 2 || ph == 3);
			pins_o.index_input <= idx_en && ph == idx_ph;
			repeat (hold) @(posedge mclk_i);
		end
		@(negedge mclk_i);
	endtask
	// High pulse on one line: 0 src, 1 aux, 2 gate, 4 B, 5 A
	task automatic pulse(input int w);
		@(posedge mclk_i);
		pins_o[w] <= 1'h1;
		repeat (hold) @(posedge mclk_i);
		pins_o[w] <= 1'h0;
		repeat (hold) @(posedge mclk_i);
		@(negedge mclk_i);
	endtask
endmodule // enc_model
`default_nettype wire

// file: dv/tb_top.sv
// Testbench for the position and edge-separation counter
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic mclk_i, rst_b_i, arm_i, disarm_i, buffered_i, samp_rise_i, aux_rise_i, gate_rise_i;
	logic src_rise_i, reload_en_i, dma_ready_i, dma_valid_o, capture_ready_o, overrun_o;
	logic save_done_o, armed_o, counting_o;
	logic [1:0] reload_phase_i;
	logic [31:0] reload_val_i, dma_data_o, count_o, save_o;
	cnt_pkg::mode_e mode_i;
	cnt_pkg::pins_s pins;
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;
	enc_model enc (.mclk_i(mclk_i), .pins_o(pins));
	counter_position_edge_separation dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .arm_i(arm_i),
		.disarm_i(disarm_i), .mode_i(mode_i), .buffered_i(buffered_i), .samp_rise_i(samp_rise_i),
		.aux_rise_i(aux_rise_i), .gate_rise_i(gate_rise_i), .src_rise_i(src_rise_i),
		.reload_en_i(reload_en_i), .reload_phase_i(reload_phase_i), .reload_val_i(reload_val_i),
		.enc_a_i(pins.enc_a), .enc_b_i(pins.enc_b), .index_input_i(pins.index_input),
		.gate_i(pins.gate), .aux_i(pins.aux), .src_i(pins.src), .dma_ready_i(dma_ready_i),
		.dma_valid_o(dma_valid_o), .dma_data_o(dma_data_o), .capture_ready_o(capture_ready_o),
		.overrun_o(overrun_o), .count_o(count_o), .save_o(save_o), .save_done_o(save_done_o),
		.armed_o(armed_o), .counting_o(counting_o));
	initial begin
		mclk_i = 1'h0;
		forever #4 mclk_i = ~mclk_i;
	end
	// Cut a hang short
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			stop_test();
		end
	end
	task stop_test();
		if (err_total == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Return to idle, then arm with the given mode
	task go(input cnt_pkg::mode_e m, input logic bf);
		@(posedge mclk_i);
		disarm_i <= 1'h1;
		mode_i <= m;
		buffered_i <= bf;
		@(posedge mclk_i);
		disarm_i <= 1'h0;
		arm_i <= 1'h1;
		@(posedge mclk_i);
		arm_i <= 1'h0;
		repeat (2) @(posedge mclk_i);
		@(negedge mclk_i);
	endtask
	// Wait for a streamed word, compare it, then accept it for one edge
	task take(input logic [31:0] exp);
		int k;
		k = 0;
		@(negedge mclk_i);
		while (dma_valid_o !== 1'h1 && k < 50) begin
			@(negedge mclk_i);
			k++;
		end
		chk(dma_data_o, exp);
		@(posedge mclk_i);
		dma_ready_i <= 1'h1;
		@(posedge mclk_i);
		dma_ready_i <= 1'h0;
		@(negedge mclk_i);
	endtask
	initial begin
		{rst_b_i, arm_i, disarm_i, buffered_i, reload_en_i, dma_ready_i} = '0;
		{samp_rise_i, aux_rise_i, gate_rise_i, src_rise_i} = 4'hf;
		reload_phase_i = 2'h0;
		reload_val_i = 32'h0000_0010;
		mode_i = cnt_pkg::MODE_X1;
		repeat (20) @(posedge mclk_i);
		rst_b_i <= 1'h1;
		@(posedge mclk_i);
		chk(capture_ready_o, 32'h1);
		enc.quad(1, 4);
		chk(count_o, 32'h0);
		go(cnt_pkg::MODE_X1, 1'h0);
		enc.quad(1, 8);
		chk(count_o, 32'h2);
		enc.quad(-1, 4);
		chk(count_o, 32'h1);
		go(cnt_pkg::MODE_X2, 1'h0);
		enc.quad(1, 4);
		chk(count_o, 32'h2);
		go(cnt_pkg::MODE_X4, 1'h0);
		enc.quad(1, 4);
		chk(count_o, 32'h4);
		enc.quad(-1, 8);
		chk(count_o, 32'hffff_fffc);
		go(cnt_pkg::MODE_TWO_PULSE, 1'h0);
		repeat (3) enc.pulse(5);
		enc.pulse(4);
		chk(count_o, 32'h2);
		// Index reload in phase 00; the step into that phase lands first
		@(posedge mclk_i) reload_en_i <= 1'h1;
		go(cnt_pkg::MODE_X4, 1'h0);
		enc.idx_en = 1'h1;
		enc.quad(1, 4);
		chk(count_o, 32'h10);
		enc.quad(1, 1);
		chk(count_o, 32'h11);
		enc.idx_en = 1'h0;
		enc.quad(-1, 1);
		// Reload in phase 11 with a new value, then index high in a phase not chosen
		@(posedge mclk_i) reload_phase_i <= 2'h3;
		@(posedge mclk_i) reload_val_i <= 32'h0000_0100;
		go(cnt_pkg::MODE_X2, 1'h0);
		enc.idx_ph = 2;
		enc.idx_en = 1'h1;
		enc.quad(1, 4);
		chk(count_o, 32'h0000_0101);
		enc.idx_ph = 1;
		enc.quad(1, 4);
		chk(count_o, 32'h0000_0103);
		enc.idx_en = 1'h0;
		@(posedge mclk_i) reload_en_i <= 1'h0;
		// Sample-clocked capture into a two-word buffer while the drain stalls
		go(cnt_pkg::MODE_X1, 1'h1);
		repeat (3) begin
			enc.quad(1, 4);
			enc.pulse(2);
		end
		chk(overrun_o, 32'h1);
		chk(count_o, 32'h3);
		take(32'h1);
		take(32'h2);
		chk(dma_valid_o, 32'h0);
		// Sample on the falling gate edge only; a new arm clears the loss flag
		@(posedge mclk_i) samp_rise_i <= 1'h0;
		go(cnt_pkg::MODE_X4, 1'h1);
		chk(overrun_o, 32'h0);
		enc.quad(1, 1);
		enc.pulse(2);
		take(32'h1);
		chk(dma_valid_o, 32'h0);
		// Single separation: early source and repeated aux edges ignored
		go(cnt_pkg::MODE_SEP_SINGLE, 1'h0);
		enc.pulse(0);
		enc.pulse(1);
		repeat (3) enc.pulse(0);
		enc.pulse(1);
		enc.pulse(0);
		enc.pulse(2);
		chk(save_o, 32'h4);
		chk(save_done_o, 32'h1);
		enc.pulse(0);
		enc.pulse(1);
		enc.pulse(2);
		chk(save_o, 32'h4);
		// Buffered separation on falling gate edges
		@(posedge mclk_i) gate_rise_i <= 1'h0;
		go(cnt_pkg::MODE_SEP_BUF, 1'h0);
		enc.pulse(1);
		repeat (2) enc.pulse(0);
		enc.pulse(2);
		repeat (3) enc.pulse(0);
		enc.pulse(2);
		take(32'h2);
		take(32'h3);
		// Falling aux and source edges; a source edge beside the aux edge is not counted
		@(posedge mclk_i) aux_rise_i <= 1'h0;
		@(posedge mclk_i) src_rise_i <= 1'h0;
		@(posedge mclk_i) gate_rise_i <= 1'h1;
		go(cnt_pkg::MODE_SEP_SINGLE, 1'h0);
		fork
			enc.pulse(1);
			enc.pulse(0);
		join
		repeat (2) enc.pulse(0);
		fork
			enc.pulse(0);
			enc.pulse(2);
		join
		chk(save_o, 32'h2);
		chk(counting_o, 32'h0);
		chk(armed_o, 32'h1);
		stop_test();
	end
endmodule // tb_top
`default_nettype wire
